// >>> rtl/bsi_pkg.sv
// Shared constants for the boundary-scan instruction port.
// Assumes the test port and the core logic sit behind one reference clock.
package bsi_pkg;

  localparam int IR_W        = 5;
  localparam int CFG_W       = 32;
  localparam int ID_W        = 32;
  localparam int CELL_BITS   = 3;
  localparam int CELL_IN     = 0;
  localparam int CELL_OUT    = 1;
  localparam int CELL_OE     = 2;
  localparam int FIFO_DEPTH  = 16;
  localparam int SYNC_FIXED  = 3;

  localparam logic [4:0] INS_EXTEST      = 5'h00;
  localparam logic [4:0] INS_SAMPLE      = 5'h01;
  localparam logic [4:0] INS_USER_REG1   = 5'h02;
  localparam logic [4:0] INS_USER_REG2   = 5'h03;
  localparam logic [4:0] INS_CFG_READ    = 5'h04;
  localparam logic [4:0] INS_CFG_WRITE   = 5'h05;
  localparam logic [4:0] INS_INTEST      = 5'h07;
  localparam logic [4:0] INS_USER_CODE   = 5'h08;
  localparam logic [4:0] INS_IDCODE      = 5'h09;
  localparam logic [4:0] INS_OUTPUTS_OFF = 5'h0A;
  localparam logic [4:0] INS_STARTUP     = 5'h0C;
  localparam logic [4:0] INS_BYPASS      = 5'h1F;
  localparam logic [4:0] IR_CAPTURE      = 5'h01;
  localparam logic [4:0] CFG_LAST_BIT    = 5'h1F;

  typedef enum logic [3:0] {
    ST_TLR        = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAPTURE_DR = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPDATE_DR  = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAPTURE_IR = 4'hA,
    ST_SHIFT_IR   = 4'hB,
    ST_EXIT1_IR   = 4'hC,
    ST_PAUSE_IR   = 4'hD,
    ST_EXIT2_IR   = 4'hE,
    ST_UPDATE_IR  = 4'hF
  } bsi_tap_t;

endpackage : bsi_pkg

// >>> rtl/bsi_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or a clock far below the sampling rate.
`timescale 1ns/10ps
module bsi_sync #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic         rst_b,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : bsi_sync

// >>> rtl/bsi_fifo.sv
// Word FIFO with a registered output stage.
// Assumes DEPTH is a power of two; in_ready falls only when storage is full.
`timescale 1ns/10ps
module bsi_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  logic         clk,
  input  logic         rst_b,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      case ({push, pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : bsi_fifo

// >>> rtl/bsi_port.sv
// Boundary-scan test access logic: tap controller, instruction decode,
// boundary chain, identification, user and configuration access.
// Assumes the test clock is far slower than ref_clk so its edges are found by sampling.
`timescale 1ns/10ps
module bsi_port
  import bsi_pkg::*;
#(
  parameter int          NUM_IO       = 8,
  parameter int          DEPTH        = bsi_pkg::FIFO_DEPTH,
  parameter logic [31:0] IDCODE_VALUE = 32'h0000_1001  // Arbitrary identification value.
) (
  input  logic                    ref_clk,
  input  logic                    rst_b,
  input  logic                    tck,
  input  logic                    tms,
  input  logic                    tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  input  logic [NUM_IO-1:0]       io_pin_in,
  output logic [NUM_IO-1:0]       io_pin_out,
  output logic [NUM_IO-1:0]       io_pin_oe,
  input  logic [NUM_IO-1:0]       core_out,
  input  logic [NUM_IO-1:0]       core_oe,
  output logic [NUM_IO-1:0]       core_in,
  input  logic                    config_done,
  input  logic [31:0]             user_code,
  input  logic                    startup_clock_select,
  output logic                    startup_step_pulse,
  output logic                    user_reset,
  output logic                    user_update,
  output logic                    user_shift,
  output logic                    user_sel1,
  output logic                    user_sel2,
  output logic                    user_tdi,
  input  logic                    user_tdo1,
  input  logic                    user_tdo2,
  output logic [bsi_pkg::CFG_W-1:0] cfg_wr_data,
  output logic                    cfg_wr_valid,
  input  logic                    cfg_wr_ready,
  input  logic [bsi_pkg::CFG_W-1:0] cfg_rd_data,
  input  logic                    cfg_rd_valid,
  output logic                    cfg_rd_taken
);

  import bsi_pkg::*;

  localparam int BW = CELL_BITS * NUM_IO;

  logic [NUM_IO+SYNC_FIXED-1:0] sync_q;
  logic                         s_tck;
  logic                         s_tms;
  logic                         s_tdi;
  logic [NUM_IO-1:0]            s_pin;
  logic                         tck_d;
  logic [2:0]                   sync_warm;
  logic                         tck_rise;
  logic                         tck_fall;
  bsi_tap_t                     tap;
  bsi_tap_t                     next_tap;
  logic [IR_W-1:0]              ir_shift;
  logic [IR_W-1:0]              instr;
  logic                         sel_bnd;
  logic                         sel_id;
  logic                         sel_cfg_in;
  logic                         sel_cfg_out;
  logic                         sel_user1;
  logic                         sel_user2;
  logic                         sel_bypass;
  logic                         bypass_bit;
  logic [ID_W-1:0]              id_shift;
  logic [BW-1:0]                bnd_shift;
  logic [BW:0]                  bnd_chain;
  logic [BW-1:0]                bnd_upd;
  logic [NUM_IO-1:0]            bnd_out_v;
  logic [NUM_IO-1:0]            bnd_oe_v;
  logic [NUM_IO-1:0]            bnd_in_v;
  logic [CFG_W-1:0]             cfg_shift;
  logic [4:0]                   cfg_cnt;
  logic                         cfg_pending;
  logic [CFG_W-1:0]             cfg_pend_data;
  logic                         fifo_in_ready;
  logic                         dr_shift_en;
  logic                         cfg_load;
  logic                         next_tdo;

  bsi_sync #(.W(NUM_IO + SYNC_FIXED)) u_sync (
    .clk   (ref_clk),
    .rst_b (rst_b),
    .d     ({io_pin_in, tdi, tms, tck}),
    .q     (sync_q)
  );

  assign s_tck    = sync_q[0];
  assign s_tms    = sync_q[1];
  assign s_tdi    = sync_q[2];
  assign s_pin    = sync_q[NUM_IO+SYNC_FIXED-1:SYNC_FIXED];
  assign tck_rise = s_tck && !tck_d && sync_warm[2];
  assign tck_fall = !s_tck && tck_d && sync_warm[2];

  // Edges count only once the synchroniser and tck_d hold real pin samples; a test
  // clock idling high would otherwise look like a rise just after reset.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_d     <= 1'b0;
      sync_warm <= '0;
    end else begin
      tck_d     <= s_tck;
      sync_warm <= {sync_warm[1:0], 1'b1};
    end
  end

  always_comb begin
    case (tap)
      ST_TLR:        next_tap = s_tms ? ST_TLR : ST_IDLE;
      ST_IDLE:       next_tap = s_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:     next_tap = s_tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: next_tap = s_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   next_tap = s_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   next_tap = s_tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   next_tap = s_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   next_tap = s_tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  next_tap = s_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:     next_tap = s_tms ? ST_TLR : ST_CAPTURE_IR;
      ST_CAPTURE_IR: next_tap = s_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   next_tap = s_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   next_tap = s_tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   next_tap = s_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   next_tap = s_tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  next_tap = s_tms ? ST_SEL_DR : ST_IDLE;
      default:       next_tap = ST_TLR;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)        tap <= ST_TLR;
    else if (tck_rise) tap <= next_tap;
  end

  // The reset value is IDCODE so identification works with no configuration loaded.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_shift <= IR_CAPTURE;
      instr    <= INS_IDCODE;
    end else if (tck_rise) begin
      case (tap)
        ST_TLR:        instr    <= INS_IDCODE;
        ST_CAPTURE_IR: ir_shift <= IR_CAPTURE;
        ST_SHIFT_IR:   ir_shift <= {s_tdi, ir_shift[IR_W-1:1]};
        ST_UPDATE_IR:  instr    <= ir_shift;
        default:       ir_shift <= ir_shift;
      endcase
    end
  end

  // Decode does not look at config_done except for the user code, which only exists once loaded.
  always_comb begin
    sel_bnd     = 1'b0;
    sel_id      = 1'b0;
    sel_cfg_in  = 1'b0;
    sel_cfg_out = 1'b0;
    sel_user1   = 1'b0;
    sel_user2   = 1'b0;
    sel_bypass  = 1'b0;
    case (instr)
      INS_EXTEST, INS_SAMPLE, INS_INTEST: sel_bnd = 1'b1;
      INS_IDCODE:    sel_id      = 1'b1;
      INS_USER_CODE: begin
        sel_id     = config_done;
        sel_bypass = !config_done;
      end
      INS_USER_REG1: sel_user1   = 1'b1;
      INS_USER_REG2: sel_user2   = 1'b1;
      INS_CFG_WRITE: sel_cfg_in  = 1'b1;
      INS_CFG_READ:  sel_cfg_out = 1'b1;
      default:       sel_bypass  = 1'b1;
    endcase
  end

  assign dr_shift_en = tck_rise && (tap == ST_SHIFT_DR);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_bit <= 1'b0;
      id_shift   <= '0;
    end else if (tck_rise && tap == ST_CAPTURE_DR) begin
      bypass_bit <= 1'b0;
      id_shift   <= (instr == INS_USER_CODE) ? user_code : IDCODE_VALUE;
    end else if (dr_shift_en) begin
      bypass_bit <= s_tdi;
      id_shift   <= {s_tdi, id_shift[ID_W-1:1]};
    end
  end

  // Capture takes the core's own drive for every cell whatever its role, so
  // unused cells show any internal signal routed to them.
  assign bnd_chain = {s_tdi, bnd_shift};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO; gi++) begin : g_cell
      assign bnd_in_v[gi]  = bnd_upd[CELL_BITS*gi + CELL_IN];
      assign bnd_out_v[gi] = bnd_upd[CELL_BITS*gi + CELL_OUT];
      assign bnd_oe_v[gi]  = bnd_upd[CELL_BITS*gi + CELL_OE];

      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          bnd_shift[CELL_BITS*gi +: CELL_BITS] <= '0;
        end else if (tck_rise && tap == ST_CAPTURE_DR && sel_bnd) begin
          bnd_shift[CELL_BITS*gi + CELL_IN]  <= s_pin[gi];
          bnd_shift[CELL_BITS*gi + CELL_OUT] <= core_out[gi];
          bnd_shift[CELL_BITS*gi + CELL_OE]  <= core_oe[gi];
        end else if (dr_shift_en && sel_bnd) begin
          bnd_shift[CELL_BITS*gi +: CELL_BITS] <=
            bnd_chain[CELL_BITS*gi + 1 +: CELL_BITS];
        end
      end

      // Drive depends only on the instruction, never on configuration state.
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          io_pin_out[gi] <= 1'b0;
          io_pin_oe[gi]  <= 1'b0;
          core_in[gi]    <= 1'b0;
        end else begin
          io_pin_out[gi] <= (instr == INS_EXTEST) ? bnd_out_v[gi] : core_out[gi];
          io_pin_oe[gi]  <= (instr == INS_OUTPUTS_OFF) ? 1'b0 :
                            (instr == INS_EXTEST) ? bnd_oe_v[gi] : core_oe[gi];
          core_in[gi]    <= (instr == INS_INTEST) ? bnd_in_v[gi] : s_pin[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)                                         bnd_upd <= '0;
    else if (tck_rise && tap == ST_UPDATE_DR && sel_bnd) bnd_upd <= bnd_shift;
  end

  // A full word waits in cfg_pending while the FIFO is full; shifting is frozen
  // meanwhile, so the test controller must slow down rather than lose bits.
  assign cfg_load = (tck_rise && tap == ST_CAPTURE_DR && sel_cfg_out) ||
                    (dr_shift_en && sel_cfg_out && cfg_cnt == CFG_LAST_BIT);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_shift     <= '0;
      cfg_cnt       <= '0;
      cfg_pending   <= 1'b0;
      cfg_pend_data <= '0;
      cfg_rd_taken  <= 1'b0;
    end else begin
      cfg_rd_taken <= cfg_load && cfg_rd_valid;
      if (cfg_pending && fifo_in_ready) cfg_pending <= 1'b0;
      if (tck_rise && tap == ST_CAPTURE_DR) cfg_cnt <= '0;
      if (cfg_load) begin
        cfg_shift <= cfg_rd_valid ? cfg_rd_data : '0;
        cfg_cnt   <= '0;
      end else if (dr_shift_en && (sel_cfg_out || (sel_cfg_in && !cfg_pending))) begin
        cfg_shift <= {s_tdi, cfg_shift[CFG_W-1:1]};
        cfg_cnt   <= cfg_cnt + 1'b1;
        if (sel_cfg_in && cfg_cnt == CFG_LAST_BIT) begin
          cfg_pending   <= 1'b1;
          cfg_pend_data <= {s_tdi, cfg_shift[CFG_W-1:1]};
        end
      end
    end
  end

  bsi_fifo #(.W(CFG_W), .DEPTH(DEPTH)) u_fifo (
    .clk       (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (cfg_pending),
    .in_ready  (fifo_in_ready),
    .in_data   (cfg_pend_data),
    .out_valid (cfg_wr_valid),
    .out_ready (cfg_wr_ready),
    .out_data  (cfg_wr_data)
  );

  always_comb begin
    next_tdo = bypass_bit;
    if (tap == ST_SHIFT_IR)   next_tdo = ir_shift[0];
    else if (sel_bnd)         next_tdo = bnd_shift[0];
    else if (sel_id)          next_tdo = id_shift[0];
    else if (sel_cfg_in)      next_tdo = cfg_shift[0];
    else if (sel_cfg_out)     next_tdo = cfg_shift[0];
    else if (sel_user1)       next_tdo = user_tdo1;
    else if (sel_user2)       next_tdo = user_tdo2;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= next_tdo;
      tdo_oe <= (tap == ST_SHIFT_IR) || (tap == ST_SHIFT_DR);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      user_reset  <= 1'b1;
      user_update <= 1'b0;
      user_shift  <= 1'b0;
      user_sel1   <= 1'b0;
      user_sel2   <= 1'b0;
      user_tdi    <= 1'b0;
    end else begin
      user_reset  <= (tap == ST_TLR);
      user_update <= (tap == ST_UPDATE_DR);
      user_shift  <= (tap == ST_SHIFT_DR);
      user_sel1   <= sel_user1;
      user_sel2   <= sel_user2;
      user_tdi    <= s_tdi;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) startup_step_pulse <= 1'b0;
    else        startup_step_pulse <= tck_rise && tap == ST_IDLE &&
                                      instr == INS_STARTUP && startup_clock_select;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_ir_capture;
    tck_rise && tap == ST_CAPTURE_IR |=> ir_shift == IR_CAPTURE;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("IR capture value wrong.");

  property p_chain_shift;
    dr_shift_en && sel_bnd |=> bnd_shift == {$past(s_tdi), $past(bnd_shift[BW-1:1])};
  endproperty
  a_chain_shift: assert property (p_chain_shift) else $error("Chain did not shift.");

  property p_extest_oe;
    instr == INS_EXTEST ##1 instr == INS_EXTEST |-> io_pin_oe == $past(bnd_oe_v);
  endproperty
  a_extest_oe: assert property (p_extest_oe) else $error("EXTEST enable wrong.");

  property p_extest_out;
    instr == INS_EXTEST |=> io_pin_out == $past(bnd_out_v);
  endproperty
  a_extest_out: assert property (p_extest_out) else $error("EXTEST drive wrong.");

  property p_capture_core;
    tck_rise && tap == ST_CAPTURE_DR && sel_bnd |=>
      bnd_shift[CELL_OUT] == $past(core_out[0]) && bnd_shift[CELL_OE] == $past(core_oe[0]);
  endproperty
  a_capture_core: assert property (p_capture_core) else $error("Capture missed core.");

  property p_reset_idcode;
    tck_rise && tap == ST_TLR |=> instr == INS_IDCODE;
  endproperty
  a_reset_idcode: assert property (p_reset_idcode) else $error("Reset lost IDCODE.");

  property p_user_code;
    instr == INS_USER_CODE |-> sel_id == config_done && sel_bypass == !config_done;
  endproperty
  a_user_code: assert property (p_user_code) else $error("User code gating wrong.");

  property p_cfg_push;
    cfg_pending && fifo_in_ready |=> !cfg_pending;
  endproperty
  a_cfg_push: assert property (p_cfg_push) else $error("Word not pushed.");

  property p_user_shift;
    tap == ST_SHIFT_DR ##1 tap == ST_SHIFT_DR |-> user_shift;
  endproperty
  a_user_shift: assert property (p_user_shift) else $error("Shift flag missing.");

  property p_outputs_off;
    instr == INS_OUTPUTS_OFF |-> sel_bypass ##1 io_pin_oe == '0;
  endproperty
  a_outputs_off: assert property (p_outputs_off) else $error("Outputs not floated.");

  property p_startup;
    startup_step_pulse |-> $past(startup_clock_select) && $past(instr) == INS_STARTUP;
  endproperty
  a_startup: assert property (p_startup) else $error("Bad start-up step.");

  c_extest_update: cover property (tck_rise && tap == ST_UPDATE_DR && instr == INS_EXTEST);
  c_cfg_word:      cover property (cfg_pending && fifo_in_ready);
  c_startup:       cover property (startup_step_pulse);
  c_user_update:   cover property (user_update && user_sel1);

endmodule : bsi_port

// >>> tb/bsi_ctl.sv
// Test controller model that drives the four-wire port from the far side.
// Assumes it is called at falling ref_clk edges; tck stands still between frames.
`timescale 1ns/10ps
module bsi_ctl (
  input  wire logic ref_clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  int half = 4;

  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock period; tdo is taken at the rise, after the low half let it settle.
  task automatic step(input logic m, input logic d, output logic o);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (half) @(negedge ref_clk);
    o = tdo;
    tck = 1'b1;
    repeat (half) @(negedge ref_clk);
  endtask : step

  // Outside shift states tdi carries no data, so it toggles rather than holding a stale bit.
  task automatic nav(input logic m);
    logic o;
    step(m, ~tdi, o);
  endtask : nav

  task automatic tap_reset();
    repeat (5) nav(1'b1);
    nav(1'b0);
  endtask : tap_reset

  // Shifts n bits LSB first from idle and returns to idle; ir picks the register.
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    dout = '0;
    nav(1'b1);
    if (ir) nav(1'b1);
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    nav(1'b1);
    nav(1'b0);
  endtask : scan
endmodule : bsi_ctl

// >>> tb/bsi_port_test.sv
// Self-checking bench for the boundary-scan port with a controller model on the pins.
// Assumes a 250 MHz ref_clk and a 32 ns test clock made by the controller model.
`timescale 1ns/10ps
module bsi_port_test;
  import bsi_pkg::*;
  localparam int          N      = 2;
  localparam int          L      = 3 * N;
  localparam logic [31:0] ID_EXP = 32'h5A3C_0E71;  // Arbitrary identification value.
  logic          ref_clk = 1'b0;
  logic          rst_b = 1'b0;
  logic [N-1:0]  io_pin_in = '0, core_out = '0, core_oe = '0;
  logic [N-1:0]  io_pin_out, io_pin_oe, core_in;
  logic          config_done = 1'b0, startup_clock_select = 1'b0;
  logic [31:0]   user_code = '0, cfg_rd_data = '0;
  logic          user_tdo1 = 1'b1, user_tdo2 = 1'b0, cfg_wr_ready = 1'b0, cfg_rd_valid = 1'b0;
  logic [31:0]   cfg_wr_data;
  logic          tck, tms, tdi, tdo, tdo_oe, startup_step_pulse, cfg_wr_valid, cfg_rd_taken;
  logic          user_reset, user_update, user_shift, user_sel1, user_sel2, user_tdi;
  logic          upd_q = 1'b0, sh_q = 1'b0, oe_q = 1'b0;
  int            bad_count = 0, n_compared = 0, n_upd = 0, n_sh = 0, n_pulse = 0;
  int            n_oe = 0, n_taken = 0;
  logic [63:0]   q[$];

  always #2 ref_clk = ~ref_clk;

  bsi_port #(.NUM_IO(N), .IDCODE_VALUE(ID_EXP)) bsi_port_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .config_done(config_done),
    .user_code(user_code), .startup_clock_select(startup_clock_select),
    .startup_step_pulse(startup_step_pulse), .user_reset(user_reset),
    .user_update(user_update), .user_shift(user_shift), .user_sel1(user_sel1),
    .user_sel2(user_sel2), .user_tdi(user_tdi), .user_tdo1(user_tdo1), .user_tdo2(user_tdo2),
    .cfg_wr_data(cfg_wr_data), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_ready(cfg_wr_ready),
    .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid), .cfg_rd_taken(cfg_rd_taken));

  bsi_ctl bsi_ctl_i (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic load(input logic [4:0] code);
    logic [63:0] o;
    bsi_ctl_i.scan(1'b1, 5, {59'h0, code}, o);
    chk("ir capture", 64'h01, o);
  endtask : load

  function automatic logic [63:0] cells(input logic [N-1:0] pin, out, oe);
    cells = '0;
    for (int i = 0; i < N; i++) begin
      cells[3*i+:3] = {oe[i], out[i], pin[i]};
    end
  endfunction : cells

  function automatic logic [N-1:0] pick(input logic [63:0] p, input int off);
    for (int i = 0; i < N; i++) begin
      pick[i] = p[3*i+off];
    end
  endfunction : pick

  always @(posedge ref_clk) begin
    upd_q <= user_update;
    sh_q <= user_shift;
    oe_q <= tdo_oe;
    if (tdo_oe && !oe_q) n_oe++;
    if (cfg_rd_taken) n_taken++;
    if (user_update && !upd_q) n_upd++;
    if (user_shift && !sh_q) n_sh++;
    if (startup_step_pulse) n_pulse++;
    if (cfg_wr_valid && cfg_wr_ready) chk("cfg word", q.pop_front(), {32'h0, cfg_wr_data});
  end

  // Whole run is near 34 us; more than eight times that means a hang.
  initial begin
    #300_000;
    bad_count++;
    close_out();
  end

  initial begin
    logic [63:0] o, d;
    logic [4:0]  codes [5] = '{INS_BYPASS, 5'h06, 5'h1E, INS_OUTPUTS_OFF, INS_STARTUP};
    void'($urandom(32'hE05B));
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("user_reset", 64'h1, {63'h0, user_reset});
    bsi_ctl_i.tap_reset();
    bsi_ctl_i.scan(1'b0, 32, 64'h0, o);
    chk("idcode", {32'h0, ID_EXP}, o);
    $display("done identification");
    core_oe = '1;
    core_out = N'($urandom());
    foreach (codes[k]) begin
      load(codes[k]);
      d = 64'($urandom());
      bsi_ctl_i.scan(1'b0, 8, d, o);
      chk("bypass", {56'h0, d[6:0], 1'b0}, o);
      if (codes[k] == INS_OUTPUTS_OFF) chk("pin oe", '0, {62'h0, io_pin_oe});
    end
    chk("startup pulses", 64'h0, 64'(n_pulse));
    $display("done bypass codes");
    repeat (3) begin
      io_pin_in = N'($urandom());
      core_out = N'($urandom());
      core_oe = N'($urandom());
      load(INS_SAMPLE);
      d = 64'($urandom());
      bsi_ctl_i.scan(1'b0, 2 * L, d, o);
      chk("sample", ((d << L) | cells(io_pin_in, core_out, core_oe)) & 64'hFFF, o);
      chk("core in", {62'h0, io_pin_in}, {62'h0, core_in});
    end
    $display("done sample");
    config_done = 1'b1;
    load(INS_EXTEST);
    d = 64'($urandom());
    bsi_ctl_i.scan(1'b0, L, d, o);
    chk("pin out", {62'h0, pick(d, CELL_OUT)}, {62'h0, io_pin_out});
    chk("pin oe", {62'h0, pick(d, CELL_OE)}, {62'h0, io_pin_oe});
    bsi_ctl_i.scan(1'b0, L, d, o);
    chk("extest capture", cells(io_pin_in, core_out, core_oe), o);
    load(INS_INTEST);
    d = 64'($urandom());
    bsi_ctl_i.scan(1'b0, L, d, o);
    chk("intest in", {62'h0, pick(d, CELL_IN)}, {62'h0, core_in});
    $display("done extest");
    for (int k = 0; k < 2; k++) begin
      load(INS_USER_REG1 + 5'(k));
      chk("user sel", {62'h0, k == 1, k == 0}, {62'h0, user_sel2, user_sel1});
      n_upd = 0;
      n_sh = 0;
      n_oe = 0;
      bsi_ctl_i.scan(1'b0, 8, 64'($urandom()), o);
      chk("user tdo", k ? 64'h0 : 64'hFF, o);
      chk("user steps", 64'h111, {52'h0, 4'(n_oe), 4'(n_upd), 4'(n_sh)});
      chk("user tdi", {63'h0, tdi}, {63'h0, user_tdi});
    end
    $display("done user registers");
    user_code = $urandom();
    load(INS_USER_CODE);
    bsi_ctl_i.scan(1'b0, 32, 64'h0, o);
    chk("user code", {32'h0, user_code}, o);
    cfg_rd_data = $urandom();
    cfg_rd_valid = 1'b1;
    load(INS_CFG_READ);
    bsi_ctl_i.scan(1'b0, 32, 64'h0, o);
    chk("readback", {32'h0, cfg_rd_data}, o);
    chk("read taken", 64'h2, 64'(n_taken));
    load(INS_CFG_WRITE);
    repeat (16) begin
      d = {32'h0, $urandom()};
      q.push_back(d);
      bsi_ctl_i.scan(1'b0, 32, d, o);
    end
    repeat (400) begin
      @(negedge ref_clk);
      cfg_wr_ready = 1'($urandom());
    end
    chk("words left", 64'h0, 64'(q.size()));
    chk("fifo empty", 64'h0, {63'h0, cfg_wr_valid});
    $display("done configuration access");
    startup_clock_select = 1'b1;
    load(INS_STARTUP);
    n_pulse = 0;
    repeat (5) bsi_ctl_i.nav(1'b0);
    chk("startup pulses", 64'h5, 64'(n_pulse));
    $display("done startup");
    close_out();
  end
endmodule : bsi_port_test
